// ---- hw/utxd_pkg.sv ----
// =====================================================================
// utxd_pkg: shared constants of the tx descriptor dma engine and its far end
// assumes: one clock, synchronous active-low reset in every user
// =====================================================================
package utxd_pkg;
  localparam int          NCH         = 4;
  localparam int          CHW         = 2;
  // descriptor word byte offsets, four aligned words per descriptor
  localparam logic [31:0] DESC_W0_OFS = 32'h0000_0000;
  localparam logic [31:0] DESC_W1_OFS = 32'h0000_0004;
  localparam logic [31:0] DESC_W2_OFS = 32'h0000_0008;
  localparam logic [31:0] DESC_W3_OFS = 32'h0000_000c;
  // word 2 fields
  localparam int          W2_OFF_LSB  = 16;
  localparam int          W2_LEN_LSB  = 0;
  // word 3 bit positions
  localparam int          W3_FIRST    = 31;
  localparam int          W3_LAST     = 30;
  localparam int          W3_OWN      = 29;
  localparam int          W3_DRAINED  = 28;
  localparam int          W3_ZLP      = 23;
  localparam int          W3_PLEN_LSB = 0;
  // per-channel state word index, register address = {chan, index}
  localparam logic [2:0]  ST_HEAD     = 3'h0;
  localparam logic [2:0]  ST_FIRST    = 3'h1;
  localparam logic [2:0]  ST_CURD     = 3'h2;
  localparam logic [2:0]  ST_CURB     = 3'h3;
  localparam logic [2:0]  ST_W4       = 3'h4;
  localparam logic [2:0]  ST_PLEN     = 3'h5;
  localparam logic [2:0]  ST_COMP     = 3'h6;
  localparam logic [2:0]  ST_UNUSED   = 3'h7;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [15:0] RST_HALF    = 16'h0000;
  // far-end memory
  localparam int          MEM_AW      = 10;
  localparam int          MEM_WORDS   = 1024;
endpackage : utxd_pkg

// ---- hw/utxd_if.sv ----
// =====================================================================
// utxd_if: link between the dma engine and the memory/fifo/software end
// assumes: all signals sampled on mclk_i of both ends
// =====================================================================
`timescale 1ns/10ps
interface utxd_if;
  import utxd_pkg::*;
  logic            mem_req;
  logic            mem_we;
  logic [31:0]     mem_addr;
  logic [31:0]     mem_wdata;
  logic            mem_ack;
  logic [31:0]     mem_rdata;
  logic            tx_valid;
  logic            tx_ready;
  logic [7:0]      tx_data;
  logic            tx_last;
  logic            tx_zlp;
  logic [CHW-1:0]  tx_chan;
  logic            sw_we;
  logic            sw_re;
  logic [4:0]      sw_addr;
  logic [31:0]     sw_wdata;
  logic [31:0]     sw_rdata;

  modport dev (output mem_req, mem_we, mem_addr, mem_wdata, input mem_ack, mem_rdata,
               output tx_valid, tx_data, tx_last, tx_zlp, tx_chan, input tx_ready,
               input sw_we, sw_re, sw_addr, sw_wdata, output sw_rdata);
  modport far (input mem_req, mem_we, mem_addr, mem_wdata, output mem_ack, mem_rdata,
               input tx_valid, tx_data, tx_last, tx_zlp, tx_chan, output tx_ready,
               output sw_we, sw_re, sw_addr, sw_wdata, input sw_rdata);
endinterface : utxd_if

// ---- hw/utxd_chstate.sv ----
// =====================================================================
// utxd_chstate: per-channel tx state words, software and engine ports
// assumes: engine updates one channel at a time
// =====================================================================
`timescale 1ns/10ps
module utxd_chstate import utxd_pkg::*; (
  input  wire logic                mclk_i,
  input  wire logic                rstn_i,
  input  wire logic                sw_we_i,
  input  wire logic                sw_re_i,
  input  wire logic [4:0]          sw_addr_i,
  input  wire logic [31:0]         sw_wdata_i,
  output logic      [31:0]         sw_rdata_o,
  input  wire logic [CHW-1:0]      eng_ch_i,
  input  wire logic                eng_st_we_i,
  input  wire logic [31:0]         eng_first_i,
  input  wire logic [31:0]         eng_curd_i,
  input  wire logic [31:0]         eng_curb_i,
  input  wire logic [31:0]         eng_plen_i,
  input  wire logic                eng_head_we_i,
  input  wire logic [31:0]         eng_head_i,
  input  wire logic                eng_comp_we_i,
  input  wire logic [31:0]         eng_comp_i,
  output logic      [NCH*32-1:0]   head_flat_o
);
  logic [NCH*32-1:0] rd_flat;

  // =====================================================================
  // one queue per channel: head and completion pointer each
  // =====================================================================
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [31:0] w [0:7];
    logic        sw_hit;
    logic        eng_sel;
    assign sw_hit  = sw_we_i && (sw_addr_i[4:3] == CHW'(g)) && (sw_addr_i[2:0] != ST_UNUSED);
    assign eng_sel = (eng_ch_i == CHW'(g));

    always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
        for (int i = 0; i < 8; i++) begin
          w[i] <= RST_WORD;
        end
      end else begin
        if (sw_hit) begin
          w[sw_addr_i[2:0]] <= sw_wdata_i;
        end
        if (eng_sel && eng_st_we_i) begin
          w[ST_FIRST] <= eng_first_i;
          w[ST_CURD]  <= eng_curd_i;
          w[ST_CURB]  <= eng_curb_i;
          w[ST_PLEN]  <= eng_plen_i;
        end
        // a software restart of the head beats the engine's own update
        if (eng_sel && eng_head_we_i && !(sw_hit && sw_addr_i[2:0] == ST_HEAD)) begin
          w[ST_HEAD] <= eng_head_i;
        end
        // completion written by hardware wins over a software acknowledge
        if (eng_sel && eng_comp_we_i) begin
          w[ST_COMP] <= eng_comp_i;
        end
      end
    end

    assign head_flat_o[g*32 +: 32] = w[ST_HEAD];
    assign rd_flat[g*32 +: 32]     = w[sw_addr_i[2:0]];
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sw_rdata_o <= RST_WORD;
    end else if (sw_re_i) begin
      sw_rdata_o <= rd_flat[sw_addr_i[4:3]*32 +: 32];
    end
  end
endmodule // utxd_chstate

// ---- hw/utxd_engine.sv ----
// =====================================================================
// utxd_engine: transmit descriptor dma, walks per-channel queues in memory
// assumes: far end acks every memory request, software keeps descriptors sane
// =====================================================================
`timescale 1ns/10ps
module utxd_engine import utxd_pkg::*; (
  input  wire logic            mclk_i,
  input  wire logic            rstn_i,
  utxd_if.dev                  lnk,
  output logic                 active_o,
  output logic [CHW-1:0]       active_chan_o
);
  typedef enum {S_IDLE, S_W0, S_W1, S_W2, S_W3, S_DRD, S_EMIT, S_ZLP,
                S_NEXT, S_WOWN, S_WDRAIN, S_DONE} utxd_state_t;

  utxd_state_t        st;
  logic [CHW-1:0]     ch;
  logic [31:0]        cur_desc;
  logic [31:0]        next_desc;
  logic [31:0]        buf_ptr;
  logic [31:0]        first_desc;
  logic [31:0]        raw_w2;
  logic [31:0]        cur_w3;
  logic [31:0]        first_w3;
  logic [31:0]        dword;
  logic [15:0]        buf_rem;
  logic [15:0]        pkt_rem;
  logic [15:0]        pkt_act;
  logic               pend;
  logic               st_we;
  logic               head_we;
  logic [31:0]        head_val;
  logic               comp_we;
  logic [NCH*32-1:0]  head_flat;
  logic               pick_ok;
  logic [CHW-1:0]     pick_ch;
  logic               beat;
  logic [15:0]        next_pkt;
  logic [15:0]        next_buf;
  logic [31:0]        own_word;
  logic [31:0]        comp_val;

  utxd_chstate u_chstate (
    .mclk_i        (mclk_i),
    .rstn_i        (rstn_i),
    .sw_we_i       (lnk.sw_we),
    .sw_re_i       (lnk.sw_re),
    .sw_addr_i     (lnk.sw_addr),
    .sw_wdata_i    (lnk.sw_wdata),
    .sw_rdata_o    (lnk.sw_rdata),
    .eng_ch_i      (ch),
    .eng_st_we_i   (st_we),
    .eng_first_i   (first_desc),
    .eng_curd_i    (cur_desc),
    .eng_curb_i    (buf_ptr),
    .eng_plen_i    ({pkt_rem, pkt_act}),
    .eng_head_we_i (head_we),
    .eng_head_i    (head_val),
    .eng_comp_we_i (comp_we),
    .eng_comp_i    (comp_val),
    .head_flat_o   (head_flat)
  );

  // =====================================================================
  // channel pick: lowest channel with a nonzero head
  // =====================================================================
  always_comb begin
    pick_ok = 1'b0;
    pick_ch = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (head_flat[i*32 +: 32] != RST_WORD) begin
        pick_ok = 1'b1;
        pick_ch = CHW'(i);
      end
    end
  end

  assign beat     = lnk.tx_valid && lnk.tx_ready;
  // first buffer loads the packet length; later ones keep the running count
  assign next_pkt = lnk.mem_rdata[W3_FIRST] ? lnk.mem_rdata[W3_PLEN_LSB +: 16]
                    : pkt_rem;
  assign next_buf = raw_w2[W2_LEN_LSB +: 16];
  // single-buffer packet on an empty queue gets both updates in one write
  assign own_word = (first_w3 & ~(32'h1 << W3_OWN))
                    | ((first_desc == cur_desc && next_desc == RST_WORD)
                       ? (32'h1 << W3_DRAINED) : RST_WORD);

  // =====================================================================
  // memory master: one request pulse, wait for its ack
  // =====================================================================
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st            <= S_IDLE;
      ch            <= '0;
      cur_desc      <= RST_WORD;
      next_desc     <= RST_WORD;
      buf_ptr       <= RST_WORD;
      first_desc    <= RST_WORD;
      raw_w2        <= RST_WORD;
      cur_w3        <= RST_WORD;
      first_w3      <= RST_WORD;
      comp_val      <= RST_WORD;
      dword         <= RST_WORD;
      buf_rem       <= RST_HALF;
      pkt_rem       <= RST_HALF;
      pkt_act       <= RST_HALF;
      pend          <= 1'b0;
      st_we         <= 1'b0;
      head_we       <= 1'b0;
      head_val      <= RST_WORD;
      comp_we       <= 1'b0;
      active_o      <= 1'b0;
      active_chan_o <= '0;
      lnk.mem_req   <= 1'b0;
      lnk.mem_we    <= 1'b0;
      lnk.mem_addr  <= RST_WORD;
      lnk.mem_wdata <= RST_WORD;
      lnk.tx_valid  <= 1'b0;
      lnk.tx_data   <= 8'h00;
      lnk.tx_last   <= 1'b0;
      lnk.tx_zlp    <= 1'b0;
      lnk.tx_chan   <= '0;
    end else begin
      lnk.mem_req   <= 1'b0;
      st_we         <= 1'b0;
      head_we       <= 1'b0;
      comp_we       <= 1'b0;
      active_o      <= (st != S_IDLE);
      active_chan_o <= ch;
      case (st)
        S_IDLE: begin
          // a head write still in flight would let the old head be picked again
          if (pick_ok && !head_we) begin
            ch       <= pick_ch;
            cur_desc <= head_flat[pick_ch*32 +: 32];
            st       <= S_W0;
          end
        end
        S_W0, S_W1, S_W2, S_W3: begin
          if (!pend) begin
            pend         <= 1'b1;
            lnk.mem_req  <= 1'b1;
            lnk.mem_we   <= 1'b0;
            lnk.mem_addr <= cur_desc + ((st == S_W0) ? DESC_W0_OFS : (st == S_W1) ? DESC_W1_OFS
                             : (st == S_W2) ? DESC_W2_OFS : DESC_W3_OFS);
          end else if (lnk.mem_ack) begin
            pend <= 1'b0;
            case (st)
              S_W0: begin
                next_desc <= lnk.mem_rdata;
                st        <= S_W1;
              end
              S_W1: begin
                buf_ptr <= lnk.mem_rdata;
                st      <= S_W2;
              end
              S_W2: begin
                raw_w2 <= lnk.mem_rdata;
                st     <= S_W3;
              end
              default: begin
                cur_w3  <= lnk.mem_rdata;
                buf_rem <= next_buf;
                pkt_rem <= next_pkt;
                if (lnk.mem_rdata[W3_FIRST]) begin
                  first_desc <= cur_desc;
                  first_w3   <= lnk.mem_rdata;
                  pkt_act    <= RST_HALF;
                  // offset counts only on the first buffer
                  buf_ptr    <= buf_ptr + {16'h0000, raw_w2[W2_OFF_LSB +: 16]};
                end
                if (lnk.mem_rdata[W3_FIRST] && !lnk.mem_rdata[W3_OWN]) begin
                  // packet still owned by the processor: park the channel
                  head_val <= RST_WORD;
                  head_we  <= 1'b1;
                  st       <= S_IDLE;
                end else if (lnk.mem_rdata[W3_ZLP]) begin
                  st <= S_ZLP;
                end else if (next_pkt == RST_HALF || next_buf == RST_HALF) begin
                  st <= S_NEXT;
                end else begin
                  st <= S_DRD;
                end
              end
            endcase
          end
        end
        S_DRD: begin
          if (!pend) begin
            pend         <= 1'b1;
            lnk.mem_req  <= 1'b1;
            lnk.mem_we   <= 1'b0;
            lnk.mem_addr <= {buf_ptr[31:2], 2'b00};
          end else if (lnk.mem_ack) begin
            pend  <= 1'b0;
            dword <= lnk.mem_rdata;
            st    <= S_EMIT;
          end
        end
        S_EMIT: begin
          if (!lnk.tx_valid) begin
            lnk.tx_valid <= 1'b1;
            lnk.tx_data  <= dword[buf_ptr[1:0]*8 +: 8];
            lnk.tx_zlp   <= 1'b0;
            lnk.tx_chan  <= ch;
            lnk.tx_last  <= (pkt_rem == 16'h0001) || (buf_rem == 16'h0001 && cur_w3[W3_LAST]);
          end else if (beat) begin
            lnk.tx_valid <= 1'b0;
            buf_ptr      <= buf_ptr + 32'h1;
            buf_rem      <= buf_rem - 16'h1;
            pkt_rem      <= pkt_rem - 16'h1;
            pkt_act      <= pkt_act + 16'h1;
            st_we        <= 1'b1;
            if (pkt_rem == 16'h0001 || buf_rem == 16'h0001) begin
              st <= S_NEXT;
            end else if (buf_ptr[1:0] == 2'b11) begin
              st <= S_DRD;
            end
          end
        end
        S_ZLP: begin
          if (!lnk.tx_valid) begin
            lnk.tx_valid <= 1'b1;
            lnk.tx_data  <= 8'h00;
            lnk.tx_zlp   <= 1'b1;
            lnk.tx_last  <= 1'b1;
            lnk.tx_chan  <= ch;
          end else if (beat) begin
            lnk.tx_valid <= 1'b0;
            st           <= S_NEXT;
          end
        end
        S_NEXT: begin
          st_we <= 1'b1;
          // a chain that ends without a last buffer is closed here as well
          if (cur_w3[W3_LAST] || next_desc == RST_WORD) begin
            st <= S_WOWN;
          end else begin
            cur_desc <= next_desc;
            st       <= S_W0;
          end
        end
        S_WOWN, S_WDRAIN: begin
          if (!pend) begin
            pend          <= 1'b1;
            lnk.mem_req   <= 1'b1;
            lnk.mem_we    <= 1'b1;
            lnk.mem_addr  <= ((st == S_WOWN) ? first_desc : cur_desc) + DESC_W3_OFS;
            lnk.mem_wdata <= (st == S_WOWN) ? own_word
                             : (cur_w3 | (32'h1 << W3_DRAINED));
          end else if (lnk.mem_ack) begin
            pend <= 1'b0;
            if (st == S_WOWN && next_desc == RST_WORD && first_desc != cur_desc) begin
              st <= S_WDRAIN;
            end else begin
              st <= S_DONE;
            end
          end
        end
        S_DONE: begin
          // cur_desc moves on here, so the finished packet's last one is kept
          comp_val <= cur_desc;
          head_val <= next_desc;
          head_we  <= 1'b1;
          comp_we  <= 1'b1;
          if (next_desc != RST_WORD) begin
            cur_desc <= next_desc;
            st       <= S_W0;
          end else begin
            st <= S_IDLE;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end
endmodule // utxd_engine

// ---- hw/utxd_far.sv ----
// =====================================================================
// utxd_far: far end, main memory slave, fifo sink, software port relay
// assumes: user side loads descriptors and buffers before starting a channel
// =====================================================================
`timescale 1ns/10ps
module utxd_far import utxd_pkg::*; (
  input  wire logic            mclk_i,
  input  wire logic            rstn_i,
  utxd_if.far                  lnk,
  input  wire logic            ld_we_i,
  input  wire logic            ld_re_i,
  input  wire logic [31:0]     ld_addr_i,
  input  wire logic [31:0]     ld_wdata_i,
  output logic      [31:0]     ld_rdata_o,
  input  wire logic            sw_we_i,
  input  wire logic            sw_re_i,
  input  wire logic [4:0]      sw_addr_i,
  input  wire logic [31:0]     sw_wdata_i,
  output logic      [31:0]     sw_rdata_o,
  input  wire logic            fifo_ready_i,
  output logic                 fifo_valid_o,
  output logic      [7:0]      fifo_data_o,
  output logic                 fifo_last_o,
  output logic                 fifo_zlp_o,
  output logic      [CHW-1:0]  fifo_chan_o
);
  logic [31:0] mem [0:MEM_WORDS-1];

  // software strobes pass straight through so read data keeps one cycle
  assign lnk.sw_we    = sw_we_i;
  assign lnk.sw_re    = sw_re_i;
  assign lnk.sw_addr  = sw_addr_i;
  assign lnk.sw_wdata = sw_wdata_i;
  assign sw_rdata_o   = lnk.sw_rdata;

  // =====================================================================
  // memory: engine writes win over a loader write in the same cycle
  // =====================================================================
  always_ff @(posedge mclk_i) begin
    if (ld_we_i) begin
      mem[ld_addr_i[MEM_AW+1:2]] <= ld_wdata_i;
    end
    if (lnk.mem_req && lnk.mem_we) begin
      mem[lnk.mem_addr[MEM_AW+1:2]] <= lnk.mem_wdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      lnk.mem_ack   <= 1'b0;
      lnk.mem_rdata <= RST_WORD;
      ld_rdata_o    <= RST_WORD;
    end else begin
      lnk.mem_ack <= lnk.mem_req;
      if (lnk.mem_req && !lnk.mem_we) begin
        lnk.mem_rdata <= mem[lnk.mem_addr[MEM_AW+1:2]];
      end
      if (ld_re_i) begin
        ld_rdata_o <= mem[ld_addr_i[MEM_AW+1:2]];
      end
    end
  end

  // =====================================================================
  // fifo sink: ready follows the user one cycle late
  // =====================================================================
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      lnk.tx_ready <= 1'b0;
      fifo_valid_o <= 1'b0;
      fifo_data_o  <= 8'h00;
      fifo_last_o  <= 1'b0;
      fifo_zlp_o   <= 1'b0;
      fifo_chan_o  <= '0;
    end else begin
      lnk.tx_ready <= fifo_ready_i;
      fifo_valid_o <= lnk.tx_valid && lnk.tx_ready;
      if (lnk.tx_valid && lnk.tx_ready) begin
        fifo_data_o <= lnk.tx_data;
        fifo_last_o <= lnk.tx_last;
        fifo_zlp_o  <= lnk.tx_zlp;
        fifo_chan_o <= lnk.tx_chan;
      end
    end
  end
endmodule // utxd_far

// ---- sim/utxd_checker.sv ----
// =====================================================================
// utxd_checker: link assertions between dma engine and far end
// assumes: one clock, sync active-low reset, instantiated beside lnk
// =====================================================================
`timescale 1ns/10ps
module utxd_checker import utxd_pkg::*; (
  input  wire logic         mclk_i,
  input  wire logic         rstn_i,
  input  wire logic         mem_req,
  input  wire logic         mem_we,
  input  wire logic [31:0]  mem_addr,
  input  wire logic [31:0]  mem_wdata,
  input  wire logic         mem_ack,
  input  wire logic         tx_valid,
  input  wire logic         tx_ready,
  input  wire logic [7:0]   tx_data,
  input  wire logic         tx_last,
  input  wire logic         tx_zlp
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // =====================================================================
  // memory link
  property p_ack_next; mem_req |=> mem_ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_cause; mem_ack |-> $past(mem_req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without req");
  property p_req_gap; mem_req |=> !mem_req; endproperty
  a_req_gap: assert property (p_req_gap) else $error("req too close");
  property p_wr_align; mem_req && mem_we |-> mem_addr[1:0] == 2'h0; endproperty
  a_wr_align: assert property (p_wr_align) else $error("unaligned write");
  property p_own_clr; mem_req && mem_we |-> !mem_wdata[W3_OWN]; endproperty
  a_own_clr: assert property (p_own_clr) else $error("ownership kept");
  // drained flag only meaningful beside the last-buffer flag
  property p_drain;
    mem_req && mem_we && mem_wdata[W3_DRAINED] |-> mem_wdata[W3_LAST];
  endproperty
  a_drain: assert property (p_drain) else $error("drained without last");
  // =====================================================================
  // byte stream
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("beat dropped");
  property p_zlp; tx_valid && tx_zlp |-> tx_last && tx_data == 8'h00; endproperty
  a_zlp: assert property (p_zlp) else $error("bad empty beat");
  property p_gap; tx_valid && tx_ready |=> !(tx_valid && tx_ready); endproperty
  a_gap: assert property (p_gap) else $error("beats too close");
endmodule // utxd_checker

// ---- sim/tb.sv ----
// =====================================================================
// tb: drives the far end user side, engine walks queues in its memory
// assumes: 10 MHz clock, engine and far end joined by one utxd_if
// =====================================================================
`timescale 1ns/10ps
module tb;
  import utxd_pkg::*;
  logic            mclk_i = 1'b0;
  logic            rstn_i = 1'b0;
  logic            ld_we_i, ld_re_i, sw_we_i, sw_re_i, fifo_ready_i;
  logic [31:0]     ld_addr_i, ld_wdata_i, sw_wdata_i, ld_rdata_o, sw_rdata_o;
  logic [4:0]      sw_addr_i;
  logic            fifo_valid_o, fifo_last_o, fifo_zlp_o, active_o;
  logic [7:0]      fifo_data_o;
  logic [CHW-1:0]  fifo_chan_o, active_chan_o;
  logic [11:0]     exp_q[$];
  int              bad_count = 0;
  int              tests_run = 0;
  utxd_if lnk ();
  utxd_engine i_utxd_engine (.mclk_i(mclk_i), .rstn_i(rstn_i), .lnk(lnk),
    .active_o(active_o), .active_chan_o(active_chan_o));
  utxd_far i_utxd_far (.mclk_i(mclk_i), .rstn_i(rstn_i), .lnk(lnk),
    .ld_we_i(ld_we_i), .ld_re_i(ld_re_i), .ld_addr_i(ld_addr_i), .ld_wdata_i(ld_wdata_i),
    .ld_rdata_o(ld_rdata_o), .sw_we_i(sw_we_i), .sw_re_i(sw_re_i), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_rdata_o(sw_rdata_o), .fifo_ready_i(fifo_ready_i),
    .fifo_valid_o(fifo_valid_o), .fifo_data_o(fifo_data_o), .fifo_last_o(fifo_last_o),
    .fifo_zlp_o(fifo_zlp_o), .fifo_chan_o(fifo_chan_o));
  utxd_checker i_utxd_checker (.mclk_i(mclk_i), .rstn_i(rstn_i), .mem_req(lnk.mem_req),
    .mem_we(lnk.mem_we), .mem_addr(lnk.mem_addr), .mem_wdata(lnk.mem_wdata),
    .mem_ack(lnk.mem_ack), .tx_valid(lnk.tx_valid), .tx_ready(lnk.tx_ready),
    .tx_data(lnk.tx_data), .tx_last(lnk.tx_last), .tx_zlp(lnk.tx_zlp));

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  // =====================================================================
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ld_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    ld_we_i <= 1'b1;
    ld_addr_i <= a;
    ld_wdata_i <= d;
    @(posedge mclk_i);
    ld_we_i <= 1'b0;
  endtask
  task automatic ld_chk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    ld_re_i <= 1'b1;
    ld_addr_i <= a;
    @(posedge mclk_i);
    ld_re_i <= 1'b0;
    #1 check(ld_rdata_o, exp);
  endtask
  task automatic sw_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    sw_we_i <= 1'b1;
    sw_addr_i <= a;
    sw_wdata_i <= d;
    @(posedge mclk_i);
    sw_we_i <= 1'b0;
  endtask
  task automatic sw_chk(input logic [4:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    sw_re_i <= 1'b1;
    sw_addr_i <= a;
    @(posedge mclk_i);
    sw_re_i <= 1'b0;
    #1 check(sw_rdata_o, exp);
  endtask
  task automatic desc(input logic [31:0] a, w0, w1, w2, w3);
    ld_wr(a, w0);
    ld_wr(a + DESC_W1_OFS, w1);
    ld_wr(a + DESC_W2_OFS, w2);
    ld_wr(a + DESC_W3_OFS, w3);
  endtask
  // start a queue, compare beats {chan,zlp,last,data}, stall ready now and then
  task automatic run(input logic [4:0] r, input logic [31:0] d);
    int n;
    sw_wr(r, d);
    for (n = 0; n < 3000 && (exp_q.size() > 0 || active_o !== 1'b0); n++) begin
      @(posedge mclk_i);
      fifo_ready_i <= (n % 5 != 3);
      #1;
      if (fifo_valid_o === 1'b1) begin
        check(32'({fifo_chan_o, fifo_zlp_o, fifo_last_o, fifo_data_o}),
              32'(exp_q.size() > 0 ? exp_q.pop_front() : 12'hfff));
        check(32'(active_chan_o), 32'(r[4:3]));
      end
    end
    if (n == 3000) begin
      bad_count++;
      $display("ERROR %0t timeout", $time);
      tally_and_finish();
    end else begin
      repeat (4) @(posedge mclk_i);
    end
  endtask
  // =====================================================================
  // scenarios
  task automatic t_regs();
    int i;
    for (i = 0; i < 32; i++) sw_chk(5'(i), RST_WORD);
    sw_wr(5'h14, 32'h5a5a_a5a5);
    sw_chk(5'h14, 32'h5a5a_a5a5);
    sw_wr(5'h17, 32'h1234_5678);
    sw_chk(5'h17, RST_WORD);
    $display("test regs done");
  endtask
  task automatic t_single();
    desc(32'h200, 32'h0, 32'h100, 32'h0002_0003, 32'he000_0003);
    exp_q = '{12'h012, 12'h013, 12'h114};
    run(5'h00, 32'h200);
    check(32'(exp_q.size()), 32'h0);
    ld_chk(32'h20c, 32'hd000_0003);
    sw_chk(5'h06, 32'h200);
    sw_chk(5'h00, RST_WORD);
    $display("test single done");
  endtask
  // three-buffer packet cut short, then an empty packet on the same queue
  task automatic t_chain();
    desc(32'h300, 32'h310, 32'h100, 32'h0000_0002, 32'ha000_0005);
    desc(32'h310, 32'h320, 32'h104, 32'h0000_0002, 32'h0);
    desc(32'h320, 32'h330, 32'h108, 32'h0000_0004, 32'h4000_0000);
    desc(32'h330, 32'h0, 32'h100, 32'h0, 32'he080_0000);
    exp_q = '{12'h410, 12'h411, 12'h414, 12'h415, 12'h518, 12'h700};
    run(5'h08, 32'h300);
    check(32'(exp_q.size()), 32'h0);
    ld_chk(32'h30c, 32'h8000_0005);
    ld_chk(32'h32c, 32'h4000_0000);
    ld_chk(32'h33c, 32'hd080_0000);
    sw_chk(5'h0e, 32'h330);
    sw_chk(5'h08, RST_WORD);
    $display("test chain done");
  endtask
  // second packet still owned by the processor parks the queue
  task automatic t_park();
    desc(32'h380, 32'h390, 32'h100, 32'h0000_0001, 32'he000_0001);
    desc(32'h390, 32'h0, 32'h104, 32'h0000_0001, 32'hc000_0001);
    exp_q = '{12'h910};
    run(5'h10, 32'h380);
    check(32'(exp_q.size()), 32'h0);
    ld_chk(32'h38c, 32'hc000_0001);
    ld_chk(32'h39c, 32'hc000_0001);
    sw_chk(5'h16, 32'h380);
    sw_chk(5'h11, 32'h380);
    sw_chk(5'h15, 32'h0000_0001);
    sw_chk(5'h10, RST_WORD);
    $display("test park done");
  endtask

  initial begin
    {ld_we_i, ld_re_i, sw_we_i, sw_re_i} = 4'h0;
    fifo_ready_i = 1'b1;
    ld_addr_i = 32'h0;
    ld_wdata_i = 32'h0;
    sw_wdata_i = 32'h0;
    sw_addr_i = 5'h00;
    repeat (6) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_regs();
    ld_wr(32'h100, 32'h1312_1110);
    ld_wr(32'h104, 32'h1716_1514);
    ld_wr(32'h108, 32'h1b1a_1918);
    t_single();
    t_chain();
    t_park();
    tally_and_finish();
  end
endmodule // tb
